// ==== include/bmp_pkg.sv ====
// Package with register map, field layout and timing constants of the modulation and pace block.
package bmp_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_STATUS          = 8'h0F;
  localparam logic [7:0] ADDR_GENERAL_CONFIG  = 8'h10;
  localparam logic [7:0] ADDR_IMPEDANCE_CFG   = 8'h18;
  localparam logic [7:0] ADDR_RESYNC_COMMAND  = 8'h09;
  localparam logic [7:0] ADDR_PACE_CONFIG     = 8'h1A;

  localparam int DATA_W = 24;

  localparam logic [23:0] RST_GENERAL_CONFIG = 24'h000000;
  localparam logic [23:0] RST_IMPEDANCE_CFG  = 24'h000800;
  localparam logic [23:0] RST_PACE_CONFIG    = 24'h000055;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int GEN_MSTR_LSB  = 0;
  localparam int GEN_IMP_ON    = 2;
  localparam int GEN_PACE_ON   = 3;
  localparam int IMP_MOD_FREQ_CODE_LSB = 8;
  localparam int IMP_DRIVE_CURRENT_MAGNITUDE_LSB = 4;
  localparam int IMP_AHPF_LSB  = 14;
  localparam int ST_DRIVE_CURRENT_MAGNITUDE_BAD  = 0;
  localparam int ST_PACE_OK    = 1;
  localparam int ST_MOD_LEVEL  = 2;
  localparam int PACE_POL_BIT  = 23;
  localparam int PACE_DIFF_BIT = 19;
  localparam int PACE_GAIN_LSB = 16;
  localparam int PACE_LBW_BIT  = 14;
  localparam int PACE_AOUT_LSB = 12;
  localparam int PACE_DACP_LSB = 4;
  localparam int PACE_DACN_LSB = 0;

  // ----------------------------------------------------------------
  // Modulation timing
  // ----------------------------------------------------------------
  // The reference tick runs at this many times the selected master rate.
  localparam longint REF_MULT    = 20;
  localparam longint MCLK_HZ     = 100000000;
  localparam longint MSTR_HZ_0   = 32768;
  localparam longint MSTR_HZ_1   = 32000;
  localparam longint MSTR_HZ_2   = 32000;
  localparam longint MSTR_HZ_3   = 31968;
  localparam int     PER_W       = 13;
  localparam int     ACC_W       = 32;

  localparam logic [31:0] INC_0 = 32'((REF_MULT * MSTR_HZ_0 * (64'd1 << 32)) / MCLK_HZ);
  localparam logic [31:0] INC_1 = 32'((REF_MULT * MSTR_HZ_1 * (64'd1 << 32)) / MCLK_HZ);
  localparam logic [31:0] INC_2 = 32'((REF_MULT * MSTR_HZ_2 * (64'd1 << 32)) / MCLK_HZ);
  localparam logic [31:0] INC_3 = 32'((REF_MULT * MSTR_HZ_3 * (64'd1 << 32)) / MCLK_HZ);

  // Output periods in reference ticks, indexed by the modulation code.
  localparam logic [12:0] PER_X4    = 13'h0005;
  localparam logic [12:0] PER_OFF1  = 13'h0008;
  localparam logic [12:0] PER_OFF2  = 13'h0010;
  localparam logic [12:0] PER_OFF3  = 13'h0024;
  localparam logic [12:0] PER_DIV4  = 13'h0050;
  localparam logic [12:0] PER_MAX   = 13'h1400;

  localparam logic [3:0] CODE_X4   = 4'h0;
  localparam logic [3:0] CODE_OFF1 = 4'h1;
  localparam logic [3:0] CODE_OFF2 = 4'h2;
  localparam logic [3:0] CODE_OFF3 = 4'h3;
  localparam logic [3:0] CODE_DIV4 = 4'h4;
  localparam logic [3:0] CODE_DIV8 = 4'h5;
  localparam logic [3:0] CODE_D16  = 4'h6;
  localparam logic [3:0] CODE_D128 = 4'h9;

  localparam logic [2:0] MAG_96UA  = 3'h7;
  localparam logic [2:0] MAG_32UA  = 3'h3;
  localparam logic [2:0] MAG_16UA  = 3'h2;
  localparam logic [2:0] MAG_8UA   = 3'h1;

  // Settings handed to the shared pace and impedance analog front end.
  typedef struct packed {
    logic [1:0] shared_analog_highpass_sel;
    logic       pace_polarity_inv;
    logic       pace_diff_off;
    logic [2:0] pace_gain;
    logic       pace_aout_lbw;
    logic [1:0] pace_aout_sel;
    logic [3:0] pace_dac_pos;
    logic [3:0] pace_dac_neg;
  } bmp_shared_fe_t;

  // Register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [23:0] wdata;
    logic        wr;
    logic        rd;
  } bmp_reg_req_t;

endpackage : bmp_pkg

// ==== core/bmp_modulation_pace.sv ====
// Modulation clock generator, drive limits and pace configuration register bank.
//
// The strobed register port is this design's own decision.
`timescale 1ns/100ps
// Overview of operation
// - The modulation clock is four times the master rate for code 0, divides by 4 to 128 for codes 4 to 9, and by 256 above.
// - Codes 1 to 3 give 2.5, 1.25 and 1/1.8 times the master rate, 32,768 Hz for setting 3.
// - The 24-bit pace configuration register sits at offset 0x1A, is read and written there, and drives the pace channel.
// - The shared front end takes its settings from both the pace and the impedance configuration registers.
// - A write to the pace or impedance configuration may break the combined stream, which is signalled and not hidden.
// - A resync command restores internal synchronisation by restarting the modulation phase.
// - The high-pass selection reaches the shared front end even while the impedance channel is off.
// - Pace detection is enabled only with modulation codes 1 and 2 and is inoperable otherwise.
module bmp_modulation_pace (
  input  wire logic                   mclk_i,
  input  wire logic                   reset_i,
  input  wire logic [7:0]             reg_addr_i,
  input  wire logic [23:0]            reg_wdata_i,
  input  wire logic                   reg_wr_i,
  input  wire logic                   reg_rd_i,
  output logic      [23:0]            reg_rdata_o,
  output logic                        mod_clk_o,
  output logic      [2:0]             drive_current_magnitude_o,
  output logic                        impedance_channel_on_o,
  output logic                        pace_enable_o,
  output bmp_pkg::bmp_shared_fe_t     shared_fe_o,
  output logic                        stream_disturb_o,
  output logic                        resync_pulse_o
);

  // ----------------------------------------------------------------
  // Register port decode
  // ----------------------------------------------------------------
  bmp_pkg::bmp_reg_req_t req;
  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  logic [23:0] general_config;
  logic [23:0] impedance_channel_config;
  logic [23:0] pace_detect_config;
  logic [23:0] status_word;
  logic [23:0] next_rdata;

  wire sel_gen    = (req.addr == bmp_pkg::ADDR_GENERAL_CONFIG);
  wire sel_imp    = (req.addr == bmp_pkg::ADDR_IMPEDANCE_CFG);
  wire sel_pace   = (req.addr == bmp_pkg::ADDR_PACE_CONFIG);
  wire sel_resync = (req.addr == bmp_pkg::ADDR_RESYNC_COMMAND);
  wire sel_status = (req.addr == bmp_pkg::ADDR_STATUS);

  wire wr_gen     = req.wr & sel_gen;
  wire wr_imp     = req.wr & sel_imp;
  wire wr_pace    = req.wr & sel_pace;
  wire wr_resync  = req.wr & sel_resync;

  wire [1:0] master_clock_sel = general_config[bmp_pkg::GEN_MSTR_LSB +: 2];
  wire       pace_requested   = general_config[bmp_pkg::GEN_PACE_ON];
  wire [3:0] mod_freq_code    = impedance_channel_config[bmp_pkg::IMP_MOD_FREQ_CODE_LSB +: 4];
  wire [2:0] drive_mag        = impedance_channel_config[bmp_pkg::IMP_DRIVE_CURRENT_MAGNITUDE_LSB +: 3];

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      general_config           <= bmp_pkg::RST_GENERAL_CONFIG;
      impedance_channel_config <= bmp_pkg::RST_IMPEDANCE_CFG;
      pace_detect_config       <= bmp_pkg::RST_PACE_CONFIG;
    end else begin
      if (wr_gen) begin
        general_config <= req.wdata;
      end
      if (wr_imp) begin
        impedance_channel_config <= req.wdata;
      end
      if (wr_pace) begin
        pace_detect_config <= req.wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Drive magnitude limit check
  // ----------------------------------------------------------------
  logic mag_allowed;
  always_comb begin
    mag_allowed = 1'b1;
    if (mod_freq_code <= bmp_pkg::CODE_OFF3) begin
      mag_allowed = 1'b1;
    end else if (mod_freq_code == bmp_pkg::CODE_DIV4) begin
      mag_allowed = (drive_mag != bmp_pkg::MAG_96UA);
    end else if (mod_freq_code == bmp_pkg::CODE_DIV8) begin
      mag_allowed = (drive_mag <= bmp_pkg::MAG_32UA);
    end else if (mod_freq_code == bmp_pkg::CODE_D16) begin
      mag_allowed = (drive_mag <= bmp_pkg::MAG_16UA);
    end else begin
      mag_allowed = (drive_mag <= bmp_pkg::MAG_8UA);
    end
  end

  // ----------------------------------------------------------------
  // Master reference tick
  // ----------------------------------------------------------------
  // A phase accumulator turns the 100 MHz clock into ticks at twenty
  // times the selected master rate; its jitter is one mclk period.
  logic [31:0] acc;
  logic [31:0] acc_inc;
  logic [32:0] acc_sum;
  logic        ref_tick;

  // The 31,968 Hz setting keeps the 32,768 Hz offset rates, so those
  // codes borrow the faster tick instead of scaling down with the master.
  wire offset_code = (mod_freq_code >= bmp_pkg::CODE_OFF1) &&
                     (mod_freq_code <= bmp_pkg::CODE_OFF3);

  always_comb begin
    case (master_clock_sel)
      2'h0:    acc_inc = bmp_pkg::INC_0;
      2'h1:    acc_inc = bmp_pkg::INC_1;
      2'h2:    acc_inc = bmp_pkg::INC_2;
      default: acc_inc = offset_code ? bmp_pkg::INC_0 : bmp_pkg::INC_3;
    endcase
  end

  assign acc_sum = {1'b0, acc} + {1'b0, acc_inc};

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      acc      <= 32'h00000000;
      ref_tick <= 1'b0;
    end else begin
      acc      <= acc_sum[31:0];
      ref_tick <= acc_sum[32];
    end
  end

  // ----------------------------------------------------------------
  // Modulation divider
  // ----------------------------------------------------------------
  logic [12:0] period;
  always_comb begin
    case (mod_freq_code)
      bmp_pkg::CODE_X4:   period = bmp_pkg::PER_X4;
      bmp_pkg::CODE_OFF1: period = bmp_pkg::PER_OFF1;
      bmp_pkg::CODE_OFF2: period = bmp_pkg::PER_OFF2;
      bmp_pkg::CODE_OFF3: period = bmp_pkg::PER_OFF3;
      default: begin
        if (mod_freq_code > bmp_pkg::CODE_D128) begin
          period = bmp_pkg::PER_MAX;
        end else begin
          period = 13'(bmp_pkg::PER_DIV4 << (mod_freq_code - bmp_pkg::CODE_DIV4));
        end
      end
    endcase
  end

  logic [3:0]  code_seen;
  logic [12:0] phase_cnt;
  logic [12:0] next_phase;
  logic        next_mod;
  wire         code_changed = (code_seen != mod_freq_code);
  wire         last_phase   = (phase_cnt >= period - 13'h0001);

  // Restarting the phase on a code change or resync keeps the output
  // glitch-free at the new ratio instead of finishing a stale period.
  always_comb begin
    next_phase = phase_cnt;
    if (wr_resync || code_changed) begin
      next_phase = 13'h0000;
    end else if (ref_tick) begin
      next_phase = last_phase ? 13'h0000 : phase_cnt + 13'h0001;
    end
  end

  assign next_mod = (next_phase < (period >> 1)) ? 1'b0 : 1'b1;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      code_seen <= bmp_pkg::RST_IMPEDANCE_CFG[bmp_pkg::IMP_MOD_FREQ_CODE_LSB +: 4];
      phase_cnt <= 13'h0000;
      mod_clk_o <= 1'b0;
    end else begin
      code_seen <= mod_freq_code;
      phase_cnt <= next_phase;
      mod_clk_o <= next_mod;
    end
  end

  // ----------------------------------------------------------------
  // Front end settings and events
  // ----------------------------------------------------------------
  wire pace_code_ok = (mod_freq_code == bmp_pkg::CODE_OFF1) ||
                      (mod_freq_code == bmp_pkg::CODE_OFF2);

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      drive_current_magnitude_o <= 3'h0;
      impedance_channel_on_o    <= 1'b0;
      pace_enable_o             <= 1'b0;
      shared_fe_o               <= '0;
      stream_disturb_o          <= 1'b0;
      resync_pulse_o            <= 1'b0;
    end else begin
      drive_current_magnitude_o <= drive_mag;
      impedance_channel_on_o    <= general_config[bmp_pkg::GEN_IMP_ON];
      pace_enable_o             <= pace_requested & pace_code_ok;
      // The high-pass selection is not gated by the channel enable.
      shared_fe_o.shared_analog_highpass_sel <=
        impedance_channel_config[bmp_pkg::IMP_AHPF_LSB +: 2];
      shared_fe_o.pace_polarity_inv <= pace_detect_config[bmp_pkg::PACE_POL_BIT];
      shared_fe_o.pace_diff_off     <= pace_detect_config[bmp_pkg::PACE_DIFF_BIT];
      shared_fe_o.pace_gain         <= pace_detect_config[bmp_pkg::PACE_GAIN_LSB +: 3];
      shared_fe_o.pace_aout_lbw     <= pace_detect_config[bmp_pkg::PACE_LBW_BIT];
      shared_fe_o.pace_aout_sel     <= pace_detect_config[bmp_pkg::PACE_AOUT_LSB +: 2];
      shared_fe_o.pace_dac_pos      <= pace_detect_config[bmp_pkg::PACE_DACP_LSB +: 4];
      shared_fe_o.pace_dac_neg      <= pace_detect_config[bmp_pkg::PACE_DACN_LSB +: 4];
      stream_disturb_o <= wr_pace | wr_imp;
      resync_pulse_o   <= wr_resync;
    end
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  always_comb begin
    status_word = 24'h000000;
    status_word[bmp_pkg::ST_DRIVE_CURRENT_MAGNITUDE_BAD] = ~mag_allowed;
    status_word[bmp_pkg::ST_PACE_OK]   = pace_code_ok;
    status_word[bmp_pkg::ST_MOD_LEVEL] = mod_clk_o;
  end

  assign next_rdata = sel_gen    ? general_config :
                      sel_imp    ? impedance_channel_config :
                      sel_pace   ? pace_detect_config :
                      sel_status ? status_word : 24'h000000;

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= 24'h000000;
    end else begin
      reg_rdata_o <= req.rd ? next_rdata : 24'h000000;
    end
  end

endmodule : bmp_modulation_pace

// ==== verification/bmp_modulation_pace_properties.sv ====
// Port checker for the modulation and pace block, bound onto every instance.
`timescale 1ns/100ps
module bmp_modulation_pace_properties (
  input logic                    mclk_i,
  input logic                    reset_i,
  input logic [7:0]              reg_addr_i,
  input logic [23:0]             reg_wdata_i,
  input logic                    reg_wr_i,
  input logic                    reg_rd_i,
  input logic [23:0]             reg_rdata_o,
  input logic                    mod_clk_o,
  input logic [2:0]              drive_current_magnitude_o,
  input logic                    impedance_channel_on_o,
  input logic                    pace_enable_o,
  input bmp_pkg::bmp_shared_fe_t shared_fe_o,
  input logic                    stream_disturb_o,
  input logic                    resync_pulse_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  wire cfg_wr = reg_wr_i && (reg_addr_i == 8'h18 || reg_addr_i == 8'h1A);
  // ----------------------------------------------------------------
  // Write sequences
  // ----------------------------------------------------------------
  sequence s_wr(a);
    reg_wr_i && reg_addr_i == a;
  endsequence
  // A second write to the same place would replace the value under test.
  sequence s_settled(a);
    s_wr(a) ##1 !(reg_wr_i && reg_addr_i == a);
  endsequence
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_disturb;
    cfg_wr |=> stream_disturb_o;
  endproperty
  a_disturb: assert property (p_disturb) else $error("disturb pulse missing");
  property p_disturb_once;
    !cfg_wr |=> !stream_disturb_o;
  endproperty
  a_disturb_once: assert property (p_disturb_once) else $error("stray disturb pulse");
  property p_resync;
    s_wr(8'h09) |=> resync_pulse_o ##1 !mod_clk_o [*2];
  endproperty
  a_resync: assert property (p_resync) else $error("resync did not restart phase");
  property p_rd_idle;
    !reg_rd_i |=> reg_rdata_o == 24'h000000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_pace_off;
    (s_wr(8'h18) ##0 !(reg_wdata_i[11:8] inside {4'h1, 4'h2})) |-> ##2 !pace_enable_o;
  endproperty
  a_pace_off: assert property (p_pace_off) else $error("pace on with bad code");
  property p_hp;
    s_settled(8'h18) |=> shared_fe_o.shared_analog_highpass_sel == $past(reg_wdata_i[15:14], 2);
  endproperty
  a_hp: assert property (p_hp) else $error("high-pass not routed");
  property p_mag;
    s_settled(8'h18) |=> drive_current_magnitude_o == $past(reg_wdata_i[6:4], 2);
  endproperty
  a_mag: assert property (p_mag) else $error("magnitude not passed on");
  property p_pace_fe;
    s_settled(8'h1A) |=> shared_fe_o.pace_dac_neg == $past(reg_wdata_i[3:0], 2)
      && shared_fe_o.pace_gain == $past(reg_wdata_i[18:16], 2);
  endproperty
  a_pace_fe: assert property (p_pace_fe) else $error("pace fields not routed");
  property p_chan_on;
    s_settled(8'h10) |=> impedance_channel_on_o == $past(reg_wdata_i[2], 2);
  endproperty
  a_chan_on: assert property (p_chan_on) else $error("channel enable wrong");
endmodule : bmp_modulation_pace_properties

bind bmp_modulation_pace bmp_modulation_pace_properties i_props (
  .mclk_i(mclk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
  .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .mod_clk_o(mod_clk_o),
  .drive_current_magnitude_o(drive_current_magnitude_o),
  .impedance_channel_on_o(impedance_channel_on_o), .pace_enable_o(pace_enable_o),
  .shared_fe_o(shared_fe_o), .stream_disturb_o(stream_disturb_o),
  .resync_pulse_o(resync_pulse_o));

// ==== verification/bmp_modulation_pace_tb.sv ====
// Self-checking testbench for the modulation and pace block.
`timescale 1ns/100ps
module bmp_modulation_pace_tb;
  logic                    mclk = 1'b0;
  logic                    rst = 1'b1;
  logic [7:0]              addr = 8'h00;
  logic [23:0]             wdata = 24'h000000;
  logic                    wr_s = 1'b0;
  logic                    rd_s = 1'b0;
  logic [23:0]             rdata;
  logic                    mod_clk, imp_on, pace_en, disturb, resync;
  logic [2:0]              mag;
  bmp_pkg::bmp_shared_fe_t fe;
  int                      n_fail = 0;
  int                      n_compared = 0;

  always #5 mclk = ~mclk;

  bmp_modulation_pace i_dut (
    .mclk_i(mclk), .reset_i(rst), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .mod_clk_o(mod_clk),
    .drive_current_magnitude_o(mag), .impedance_channel_on_o(imp_on),
    .pace_enable_o(pace_en), .shared_fe_o(fe), .stream_disturb_o(disturb),
    .resync_pulse_o(resync));

  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge mclk);
    wr_s <= 1'b0;
    #1;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    @(posedge mclk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge mclk);
    rd_s <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd

  // Counts clock cycles up to the next rising edge of the modulation output.
  task automatic rise(output int n);
    n = 0;
    while (mod_clk !== 1'b0 && n < 30000) begin
      @(posedge mclk);
      #1;
      n++;
    end
    while (mod_clk !== 1'b1 && n < 30000) begin
      @(posedge mclk);
      #1;
      n++;
    end
  endtask : rise

  // A deviation of up to three clocks is tolerated on the period.
  task automatic meas(input logic [1:0] s, input logic [3:0] c, input int f);
    int n;
    int e;
    e = 100000000 / f;
    wr(8'h10, {22'h000000, s});
    wr(8'h18, {12'h000, c, 8'h00});
    rise(n);
    rise(n);
    chk(24'(n), (n - e <= 3 && e - n <= 3) ? 24'(n) : 24'(e));
  endtask : meas

  task automatic test_done;
    $display("TB: compared=%0d failed=%0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    chk({6'h00, fe}, 24'h000055);
    rd(8'h10, 24'h000000);
    rd(8'h18, 24'h000800);
    rd(8'h1A, 24'h000055);
    rd(8'h33, 24'h000000);
    $display("test reset done");
  endtask : t_reset

  task automatic t_pace;
    wr(8'h1A, 24'h8B7036);
    chk(24'(disturb), 24'h000001);
    @(posedge mclk);
    #1;
    chk(24'(disturb), 24'h000000);
    chk({6'h00, fe}, {6'h00, 2'h0, 1'h1, 1'h1, 3'h3, 1'h1, 2'h3, 4'h3, 4'h6});
    rd(8'h1A, 24'h8B7036);
    wr(8'h09, 24'h000001);
    chk(24'(resync), 24'h000001);
    @(posedge mclk);
    #1;
    chk(24'(mod_clk), 24'h000000);
    $display("test pace done");
  endtask : t_pace

  task automatic t_codes;
    wr(8'h18, 24'h008800);
    wr(8'h10, 24'h000008);
    for (int c = 0; c < 16; c++) begin
      wr(8'h18, 24'h008000 | 24'(c << 8));
      @(posedge mclk);
      #1;
      chk(24'(pace_en), 24'(c == 1 || c == 2));
      chk(24'(fe.shared_analog_highpass_sel), 24'h000002);
      rd(8'h0F, (c == 1 || c == 2) ? 24'h000002 : 24'h000000);
    end
    chk(24'(imp_on), 24'h000000);
    wr(8'h18, 24'h000460);
    @(posedge mclk);
    #1;
    chk(24'(mag), 24'h000006);
    rd(8'h0F, 24'h000000);
    $display("test codes done");
  endtask : t_codes

  task automatic t_mod;
    meas(2'h0, 4'h0, 131072);
    chk(24'(mod_clk), 24'h000001);
    wr(8'h09, 24'h000000);
    chk(24'(mod_clk), 24'h000000);
    meas(2'h0, 4'h1, 81920);
    meas(2'h0, 4'h2, 40960);
    meas(2'h0, 4'h3, 18204);
    meas(2'h0, 4'h4, 8192);
    meas(2'h1, 4'h0, 128000);
    meas(2'h1, 4'h1, 80000);
    meas(2'h1, 4'h3, 17780);
    meas(2'h3, 4'h1, 81920);
    $display("test modulation done");
  endtask : t_mod

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    #1;
    t_reset();
    t_pace();
    t_codes();
    t_mod();
    test_done();
  end

  initial begin
    #700000;
    n_fail++;
    test_done();
  end
endmodule : bmp_modulation_pace_tb
